// *** rtl/io_cell_pkg.sv ***
// Shared constants, register map and modes of the programmable I/O cell.
package io_cell_pkg;

    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int SLOTS = 2;

    // Register byte offsets.
    localparam logic [7:0] CFG_OFS = 8'h00;
    localparam logic [7:0] SHIFT_OFS = 8'h04;
    localparam logic [7:0] STAT_OFS = 8'h08;
    localparam logic [7:0] DATA_OFS = 8'h0C;

    // Configuration register layout.
    localparam int CFG_W = 17;
    localparam logic [CFG_W-1:0] CFG_RESET = 17'h00000;
    localparam int CFG_IN_LSB = 0;
    localparam int CFG_OUT_LSB = 2;
    localparam int CFG_BYPASS = 4;
    localparam int CFG_ESEL_LSB = 5;
    localparam int CFG_USE_STROBE = 7;
    localparam int CFG_STROBE_SLOT = 8;
    localparam int CFG_DIFF = 9;
    localparam int CFG_BOTTOM = 10;
    localparam int CFG_DYN_DEL = 11;
    localparam int CFG_FIX_DEL_LSB = 12;
    localparam int CFG_INIT = 16;

    // Write clock shift register layout.
    localparam int SHIFT_W = 9;
    localparam logic [SHIFT_W-1:0] SHIFT_RESET = 9'h000;
    localparam int SHIFT_STATIC_EN = 8;
    localparam int SHIFT_INV_BIT = 7;
    localparam int SHIFT_STEP_PS = 25;
    localparam int SHIFT_STEPS = 128;

    // Status and data register layout.
    localparam int ST_DLL_LSB = 8;
    localparam int ST_PRE = 15;
    localparam int ST_VALID = 16;
    localparam int ST_ARMED = 17;
    localparam int DATA_SLOT_W = 4;

    localparam int DELAY_TAPS = 16;
    localparam int SYNC_W = 30;
    localparam logic TS_OFF = 1'b1;

    typedef enum logic [1:0] {
        MODE_SDR = 2'b00,
        MODE_DDR = 2'b01,
        MODE_GEAR = 2'b10
    } rate_mode_e;

endpackage

// *** rtl/sync2.sv ***
// Two flip-flop synchroniser for levels from outside the pclk domain.
`timescale 1ns/100ps
module sync2 #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_reg <= '0;
            q <= '0;
        end
        else
        begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule // sync2

// *** rtl/tap_delay.sv ***
// Selectable input delay line; tap 0 is two register stages.
`timescale 1ns/100ps
module tap_delay (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Data and tap select
    input wire logic d,
    input wire logic [3:0] sel,
    output logic q
);
    logic [io_cell_pkg::DELAY_TAPS-1:0] chain_reg;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            chain_reg <= '0;
            q <= 1'b0;
        end
        else
        begin
            chain_reg <= {chain_reg[io_cell_pkg::DELAY_TAPS-2:0], d};
            q <= chain_reg[sel];
        end
    end
endmodule // tap_delay

// *** rtl/io_cell_pair.sv ***
// Programmable I/O cell with two slots, configured over APB.
//
// Overview of operation
// - Cell holds two slots, each own pad.
// - Slot drives data and tristate, reads pad.
// - Two slots pair as true/complement differential.
// - Synchronised, registered input on separate bypass port.
// - Four data ports; strobe pad reuses fourth.
// - Clock enable gates input registers; output registers too unless bypass set.
// - One system clock drives all register blocks.
// - Each slot muxes one of two edge clocks.
// - Latch enable guarantees double-rate input gearing.
// - Four-bit dynamic input delay code.
// - Seven-bit shift steps, 128 of 25ps.
// - Bit 7 inverts; static code may override.
// - Output gearing uses two quadrature clocks.
// - Strobe write clock serves strobe slot only.
// - Seven-bit DLL code is readable in the status register.
// - Data-valid flag marks captured input data.
// - Preamble detect biased high while strobe tristated.
// - Core gives SDR tristate to each slot except strobe slot in gear mode.
// - Strobe, gearing, valid ports absent on bottom.
// - Bottom edge: single input register, no DDR.
// - Slot has input, output, tristate, control blocks.
// - Transfer polarity picks safe transfer edge.
// - SDR input captured by system clock register.
// - DDR samples both edges, then resynchronises.
`timescale 1ns/100ps
module io_cell_pair (
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Core fabric, pclk domain
    input wire logic clk_enable,
    input wire logic local_set_reset,
    input wire logic global_set_reset_n,
    input wire logic [1:0] core_out_a_rise,
    input wire logic [1:0] core_out_a_fall,
    input wire logic [1:0] core_out_b_rise,
    input wire logic [1:0] core_out_b_fall,
    input wire logic [1:0] core_tristate_in,
    output logic [1:0] core_in_a_pos,
    output logic [1:0] core_in_a_neg,
    output logic [1:0] core_in_b_pos,
    output logic [1:0] core_in_b_neg,
    output logic [1:0] bypass_input,
    output logic [1:0] pad_clock_route,
    output logic capture_valid_flag,
    output logic preamble_detect,
    // Clocks, strobes and codes from outside the pclk domain
    input wire logic edge_clk_first,
    input wire logic edge_clk_second,
    input wire logic shifted_read_strobe,
    input wire logic transfer_polarity,
    input wire logic gear_latch_enable,
    input wire logic [3:0] input_delay_code,
    input wire logic [7:0] write_clk_shift_code,
    input wire logic [6:0] dll_delay_code,
    input wire logic write_gear_clk_a,
    input wire logic write_gear_clk_b,
    input wire logic strobe_write_clk,
    input wire logic raw_strobe_in,
    // Pad buffers
    input wire logic [1:0] pad_in,
    output logic [1:0] pad_out,
    output logic [1:0] pad_tristate_ctl
);
    ////////////////////////////////////////////////////////////////////////////
    logic [io_cell_pkg::SYNC_W-1:0] sync_q;
    logic [1:0] pad_s;
    logic ecl1_s, ecl2_s, rstrobe_s, xpol_s, lat_s, ga_s, gb_s, sw_s, raw_s;
    logic [3:0] idc_s;
    logic [7:0] wcs_s;
    logic [6:0] dll_s;

    sync2 #(.W(io_cell_pkg::SYNC_W)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d({pad_in, edge_clk_first, edge_clk_second, shifted_read_strobe,
            transfer_polarity, gear_latch_enable, input_delay_code,
            write_clk_shift_code, dll_delay_code, write_gear_clk_a,
            write_gear_clk_b, strobe_write_clk, raw_strobe_in}),
        .q(sync_q)
    );

    assign {pad_s, ecl1_s, ecl2_s, rstrobe_s, xpol_s, lat_s, idc_s, wcs_s,
            dll_s, ga_s, gb_s, sw_s, raw_s} = sync_q;

    ////////////////////////////////////////////////////////////////////////////
    logic [io_cell_pkg::CFG_W-1:0] cfg_reg;
    logic [io_cell_pkg::SHIFT_W-1:0] shift_reg;
    logic [31:0] rd_next;
    logic err_next, apb_setup, apb_wr;
    logic [1:0] valid, out_q, ts_q, din;
    logic armed_reg, sw_prev_reg, strobe_tri, cap_ok, sw_rise, ga_e, gb_e, sr;
    logic [7:0] eff_code;

    assign apb_setup = psel & ~penable;
    assign apb_wr = psel & penable & pready & pwrite;

    always_comb
    begin
        rd_next = 32'h0000_0000;
        err_next = 1'b0;
        unique case (paddr)
            io_cell_pkg::CFG_OFS: rd_next[io_cell_pkg::CFG_W-1:0] = cfg_reg;
            io_cell_pkg::SHIFT_OFS: rd_next[io_cell_pkg::SHIFT_W-1:0] = shift_reg;
            io_cell_pkg::STAT_OFS:
            begin
                rd_next[7:0] = eff_code;
                rd_next[io_cell_pkg::ST_DLL_LSB +: 7] = dll_s;
                rd_next[io_cell_pkg::ST_PRE] = preamble_detect;
                rd_next[io_cell_pkg::ST_VALID] = capture_valid_flag;
                rd_next[io_cell_pkg::ST_ARMED] = armed_reg;
                err_next = pwrite;
            end
            io_cell_pkg::DATA_OFS:
            begin
                rd_next[2*io_cell_pkg::DATA_SLOT_W-1:0] = {core_in_b_neg[1],
                    core_in_b_pos[1], core_in_a_neg[1], core_in_a_pos[1],
                    core_in_b_neg[0], core_in_b_pos[0], core_in_a_neg[0],
                    core_in_a_pos[0]};
                err_next = pwrite;
            end
            default: err_next = 1'b1;
        endcase
    end

    // The answer is prepared in the setup phase so every access takes one wait-free cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= apb_setup;
            pslverr <= apb_setup & err_next;
            if (apb_setup)
                prdata <= pwrite ? 32'h0000_0000 : rd_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_reg <= io_cell_pkg::CFG_RESET;
            shift_reg <= io_cell_pkg::SHIFT_RESET;
        end
        else if (apb_wr && paddr == io_cell_pkg::CFG_OFS)
            cfg_reg <= pwdata[io_cell_pkg::CFG_W-1:0];
        else if (apb_wr && paddr == io_cell_pkg::SHIFT_OFS)
            shift_reg <= pwdata[io_cell_pkg::SHIFT_W-1:0];
    end

    ////////////////////////////////////////////////////////////////////////////
    io_cell_pkg::rate_mode_e in_mode, out_mode;
    logic bypass, use_strobe, strobe_slot, diff, bottom, init;
    logic [1:0] esel;
    logic [3:0] del_code;

    assign in_mode = io_cell_pkg::rate_mode_e'(cfg_reg[io_cell_pkg::CFG_IN_LSB +: 2]);
    assign out_mode = io_cell_pkg::rate_mode_e'(cfg_reg[io_cell_pkg::CFG_OUT_LSB +: 2]);
    assign bypass = cfg_reg[io_cell_pkg::CFG_BYPASS];
    assign esel = cfg_reg[io_cell_pkg::CFG_ESEL_LSB +: 2];
    assign use_strobe = cfg_reg[io_cell_pkg::CFG_USE_STROBE];
    assign strobe_slot = cfg_reg[io_cell_pkg::CFG_STROBE_SLOT];
    assign diff = cfg_reg[io_cell_pkg::CFG_DIFF];
    assign bottom = cfg_reg[io_cell_pkg::CFG_BOTTOM];
    assign init = cfg_reg[io_cell_pkg::CFG_INIT];
    assign del_code = cfg_reg[io_cell_pkg::CFG_DYN_DEL] ? idc_s
        : cfg_reg[io_cell_pkg::CFG_FIX_DEL_LSB +: 4];
    assign sr = local_set_reset | ~global_set_reset_n;
    // The shift itself is analog; only the step count and inversion are handled here.
    assign eff_code = shift_reg[io_cell_pkg::SHIFT_STATIC_EN] ? shift_reg[7:0]
        : wcs_s;
    assign ga_e = ga_s ^ eff_code[io_cell_pkg::SHIFT_INV_BIT];
    assign gb_e = gb_s ^ eff_code[io_cell_pkg::SHIFT_INV_BIT];
    assign sw_rise = sw_s & ~sw_prev_reg;
    assign strobe_tri = ts_q[strobe_slot];
    assign cap_ok = ~use_strobe | armed_reg;

    ////////////////////////////////////////////////////////////////////////////
    // One slot per pad: input, output, tristate and control logic.
    for (genvar i = 0; i < io_cell_pkg::SLOTS; i++)
    begin : g_slot
        logic edge_clk, cap_clk, cap_prev_reg, rise, fall, xfer, strobe_pad, ld;
        logic pos_reg, neg_reg, st_pos_reg, st_neg_reg, valid_reg;
        logic a_pos_reg, a_neg_reg, b_pos_reg, b_neg_reg;
        logic ar_reg, af_reg, br_reg, bf_reg, out_q_reg, ts_q_reg;
        io_cell_pkg::rate_mode_e imode, omode;

        assign edge_clk = esel[i] ? ecl2_s : ecl1_s;
        assign cap_clk = use_strobe ? rstrobe_s : edge_clk;
        assign rise = cap_clk & ~cap_prev_reg;
        assign fall = ~cap_clk & cap_prev_reg;
        assign xfer = xpol_s ? fall : rise;
        assign strobe_pad = use_strobe & (int'(strobe_slot) == i);
        assign imode = bottom ? io_cell_pkg::MODE_SDR : in_mode;
        assign omode = bottom ? io_cell_pkg::MODE_SDR : out_mode;
        assign ld = clk_enable | bypass;

        tap_delay u_delay (
            .pclk(pclk),
            .presetn(presetn),
            .d(pad_s[i]),
            .sel(del_code),
            .q(din[i])
        );

        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                cap_prev_reg <= 1'b0;
            else
                cap_prev_reg <= cap_clk;
        end

        // Input register block.
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                {pos_reg, neg_reg, st_pos_reg, st_neg_reg} <= 4'h0;
                {a_pos_reg, a_neg_reg, b_pos_reg, b_neg_reg} <= 4'h0;
            end
            else if (sr)
            begin
                {pos_reg, neg_reg, st_pos_reg, st_neg_reg} <= {4{init}};
                {a_pos_reg, a_neg_reg, b_pos_reg, b_neg_reg} <= {4{init}};
            end
            else if (clk_enable)
            begin
                unique case (imode)
                    io_cell_pkg::MODE_SDR: a_pos_reg <= din[i];
                    io_cell_pkg::MODE_DDR, io_cell_pkg::MODE_GEAR:
                    begin
                        if (rise && cap_ok)
                            pos_reg <= din[i];
                        if (fall && cap_ok)
                            neg_reg <= din[i];
                        if (xfer && cap_ok && imode == io_cell_pkg::MODE_DDR)
                        begin
                            a_pos_reg <= pos_reg;
                            a_neg_reg <= neg_reg;
                        end
                        else if (xfer && cap_ok)
                        begin
                            st_pos_reg <= pos_reg;
                            st_neg_reg <= neg_reg;
                            if (lat_s)
                            begin
                                a_pos_reg <= st_pos_reg;
                                a_neg_reg <= st_neg_reg;
                                b_pos_reg <= pos_reg;
                                b_neg_reg <= neg_reg;
                            end
                        end
                    end
                    default: a_pos_reg <= a_pos_reg;
                endcase
            end
        end

        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                valid_reg <= 1'b0;
            else if (imode == io_cell_pkg::MODE_SDR)
                valid_reg <= clk_enable & ~sr;
            else
                valid_reg <= clk_enable & ~sr & xfer & cap_ok
                    & (imode == io_cell_pkg::MODE_DDR | lat_s);
        end

        // Output register block.
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                {ar_reg, af_reg, br_reg, bf_reg} <= 4'h0;
            else if (sr)
                {ar_reg, af_reg, br_reg, bf_reg} <= {4{init}};
            else if (ld)
                {ar_reg, af_reg, br_reg, bf_reg} <= {core_out_a_rise[i],
                    core_out_a_fall[i], core_out_b_rise[i], core_out_b_fall[i]};
        end

        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                out_q_reg <= 1'b0;
            else
            begin
                unique case (omode)
                    io_cell_pkg::MODE_SDR: out_q_reg <= ar_reg;
                    io_cell_pkg::MODE_DDR: out_q_reg <= edge_clk ? ar_reg : af_reg;
                    io_cell_pkg::MODE_GEAR:
                    begin
                        case ({ga_e, gb_e})
                            2'b00: out_q_reg <= ar_reg;
                            2'b10: out_q_reg <= af_reg;
                            2'b11: out_q_reg <= br_reg;
                            default: out_q_reg <= strobe_pad ? br_reg : bf_reg;
                        endcase
                    end
                    default: out_q_reg <= init;
                endcase
            end
        end

        // Tristate register block.
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                ts_q_reg <= io_cell_pkg::TS_OFF;
            else if (sr)
                ts_q_reg <= io_cell_pkg::TS_OFF;
            else if (strobe_pad && omode == io_cell_pkg::MODE_GEAR)
            begin
                if (sw_rise)
                    ts_q_reg <= bf_reg;
            end
            else if (clk_enable)
                ts_q_reg <= core_tristate_in[i];
        end

        assign out_q[i] = out_q_reg;
        assign ts_q[i] = ts_q_reg;
        assign valid[i] = valid_reg;
        assign core_in_a_pos[i] = a_pos_reg;
        assign core_in_a_neg[i] = a_neg_reg;
        assign core_in_b_pos[i] = b_pos_reg;
        assign core_in_b_neg[i] = b_neg_reg;
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pad_out <= 2'h0;
            pad_tristate_ctl <= {2{io_cell_pkg::TS_OFF}};
        end
        else
        begin
            pad_out <= diff ? {~out_q[0], out_q[0]} : out_q;
            pad_tristate_ctl <= diff ? {2{ts_q[0]}} : ts_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bypass_input <= 2'h0;
            pad_clock_route <= 2'h0;
        end
        else
        begin
            bypass_input <= pad_s;
            pad_clock_route <= pad_s;
        end
    end

    // Capture stays disarmed until the strobe leaves its idle-high bias.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            preamble_detect <= 1'b1;
            armed_reg <= 1'b0;
            sw_prev_reg <= 1'b0;
        end
        else
        begin
            preamble_detect <= strobe_tri | raw_s;
            sw_prev_reg <= sw_s;
            if (strobe_tri)
                armed_reg <= 1'b0;
            else if (!preamble_detect)
                armed_reg <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            capture_valid_flag <= 1'b0;
        else
            capture_valid_flag <= ~bottom & (|valid);
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    apb_ready_a: assert property (apb_setup |=> pready ##1 !pready)
        else $error("pready not one cycle after setup");
    sdr_capture_a: assert property ((in_mode == io_cell_pkg::MODE_SDR && clk_enable
        && !sr) |=> core_in_a_pos[0] == $past(din[0]))
        else $error("SDR input not captured");
    set_reset_a: assert property (sr |=> core_in_a_pos == {2{$past(init)}})
        else $error("set/reset did not load initial state");
    ce_hold_a: assert property ((!clk_enable && !sr) |=> $stable(core_in_a_neg))
        else $error("input register moved without enable");
    diff_pair_a: assert property (diff |=> pad_out[1] != pad_out[0])
        else $error("complement pad not inverted");
    preamble_bias_a: assert property (strobe_tri |=> preamble_detect)
        else $error("preamble not biased high while tristated");
    bottom_valid_a: assert property (bottom |=> !capture_valid_flag)
        else $error("valid flag on bottom edge");
    bypass_path_a: assert property (##3 1 |-> bypass_input == $past(pad_in, 3))
        else $error("bypass input not three cycles behind pad");
    ts_sdr_a: assert property ((clk_enable && !sr && !use_strobe)
        |=> g_slot[1].ts_q_reg == $past(core_tristate_in[1]))
        else $error("tristate register missed core value");

    ddr_valid_c: cover property (in_mode == io_cell_pkg::MODE_DDR ##1 capture_valid_flag);
    gear_out_c: cover property (out_mode == io_cell_pkg::MODE_GEAR ##1 $changed(pad_out));
    preamble_c: cover property (use_strobe && !preamble_detect);
    cfg_write_c: cover property (apb_wr && paddr == io_cell_pkg::CFG_OFS);
endmodule // io_cell_pair

// *** sim/pad_model.sv ***
// Pad buffer model: echoes driven data, pulled high when released.
`timescale 1ns/100ps
module pad_model (
    // Cell side
    input wire logic [1:0] pad_out,
    input wire logic [1:0] pad_tristate_ctl,
    // Buffer input
    output logic [1:0] pad_in
);
    // A released pad reads the pull-up, never a stale driven value.
    assign pad_in = pad_out | pad_tristate_ctl;
endmodule // pad_model

// *** sim/io_cell_pair_test.sv ***
// Self-checking bench for the I/O cell pair.
`timescale 1ns/100ps
module io_cell_pair_test;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, preamble_detect;
    logic clk_enable, local_set_reset, global_set_reset_n;
    logic [7:0] paddr, write_clk_shift_code;
    logic [31:0] pwdata, prdata;
    logic [1:0] core_out_a_rise, core_tristate_in, core_in_a_pos, bypass_input;
    logic [1:0] pad_clock_route, pad_in, pad_out, pad_tristate_ctl;
    logic [1:0] core_out_a_fall, core_out_b_rise, core_out_b_fall;
    logic edge_clk_first, edge_clk_second, write_gear_clk_a, write_gear_clk_b;
    logic raw_strobe_in, capture_valid_flag;
    logic [6:0] dll_delay_code;
    logic [3:0] input_delay_code;
    int err_total, n_checks;
    // Gear phase {a, b} = 00, 01, 10, 11 picks a_rise, b_fall, a_fall, b_rise.
    localparam logic [7:0] GEAR_EXP = 8'hE1;

    io_cell_pair dut_u (
        .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
        .pslverr, .clk_enable, .local_set_reset, .global_set_reset_n, .core_out_a_rise,
        .core_out_a_fall, .core_out_b_rise, .core_out_b_fall,
        .core_tristate_in, .core_in_a_pos, .core_in_a_neg(), .core_in_b_pos(),
        .core_in_b_neg(), .bypass_input, .pad_clock_route, .capture_valid_flag,
        .preamble_detect, .edge_clk_first, .edge_clk_second,
        .shifted_read_strobe(1'h0), .transfer_polarity(1'h0), .gear_latch_enable(1'h0),
        .input_delay_code, .write_clk_shift_code, .dll_delay_code,
        .write_gear_clk_a, .write_gear_clk_b, .strobe_write_clk(1'h0),
        .raw_strobe_in, .pad_in, .pad_out, .pad_tristate_ctl
    );

    pad_model pad_u (.pad_out, .pad_tristate_ctl, .pad_in);

    ////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // Read data and error are taken only at the edge that samples pready high.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        input logic [31:0] mask, input logic [31:0] exp, input logic err, input string what);
        int n;
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'h1 && n < 16);
        if (pready !== 1'h1)
        begin
            err_total++;
            report_and_stop();
        end
        if (!wr)
            check(what, prdata & mask, exp);
        check(what, {31'h0, pslverr}, {31'h0, err});
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask

    ////////////////////////////////////////////////////////////////
    initial
    begin
        pclk = 1'h0;
        forever #50 pclk = ~pclk;
    end

    initial
    begin
        err_total = 0;
        n_checks = 0;
        presetn = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        clk_enable = 1'h1;
        local_set_reset = 1'h0;
        global_set_reset_n = 1'h1;
        core_out_a_rise = 2'h0;
        core_out_a_fall = 2'h2;
        core_out_b_rise = 2'h3;
        core_out_b_fall = 2'h0;
        edge_clk_first = 1'h1;
        edge_clk_second = 1'h0;
        write_gear_clk_a = 1'h0;
        write_gear_clk_b = 1'h0;
        raw_strobe_in = 1'h0;
        core_tristate_in = 2'h3;
        input_delay_code = 4'h0;
        write_clk_shift_code = 8'hA5;
        dll_delay_code = 7'h3C;
        cyc(4);
        presetn <= 1'h1;
        check("reset tristate", {30'h0, pad_tristate_ctl}, 32'h3);
        check("reset preamble", {31'h0, preamble_detect}, 32'h1);
        apb(1'h0, io_cell_pkg::CFG_OFS, 32'h0, 32'hFFFFFFFF, 32'h0, 1'h0, "cfg");
        apb(1'h0, io_cell_pkg::STAT_OFS, 32'h0, 32'hFFFF, 32'hBCA5, 1'h0, "stat");
        apb(1'h1, io_cell_pkg::SHIFT_OFS, 32'h15A, 32'h0, 32'h0, 1'h0, "shift wr");
        apb(1'h0, io_cell_pkg::SHIFT_OFS, 32'h0, 32'hFFFFFFFF, 32'h15A, 1'h0, "shift");
        apb(1'h0, io_cell_pkg::STAT_OFS, 32'h0, 32'hFF, 32'h5A, 1'h0, "static");
        apb(1'h1, io_cell_pkg::STAT_OFS, 32'h0, 32'h0, 32'h0, 1'h1, "ro wr");
        apb(1'h0, 8'h10, 32'h0, 32'hFFFFFFFF, 32'h0, 1'h1, "unmapped");
        $display("register test done");
        core_tristate_in <= 2'h2;
        cyc(8);
        check("tristate", {30'h0, pad_tristate_ctl}, 32'h2);
        check("bypass", {30'h0, bypass_input}, 32'h2);
        check("clk route", {30'h0, pad_clock_route}, 32'h2);
        check("sdr in", {30'h0, core_in_a_pos}, 32'h2);
        check("valid sdr", {31'h0, capture_valid_flag}, 32'h1);
        check("preamble low", {31'h0, preamble_detect}, 32'h0);
        clk_enable <= 1'h0;
        core_out_a_rise <= 2'h1;
        cyc(8);
        check("enable hold", {30'h0, pad_out}, 32'h0);
        check("valid hold", {31'h0, capture_valid_flag}, 32'h0);
        clk_enable <= 1'h1;
        cyc(10);
        check("sdr out", {30'h0, pad_out}, 32'h1);
        check("loop in", {30'h0, core_in_a_pos}, 32'h3);
        apb(1'h0, io_cell_pkg::DATA_OFS, 32'h0, 32'hFF, 32'h11, 1'h0, "data");
        raw_strobe_in <= 1'h1;
        apb(1'h1, io_cell_pkg::CFG_OFS, 32'h44, 32'h0, 32'h0, 1'h0, "ddr cfg");
        cyc(8);
        check("ddr edge first", {30'h0, pad_out}, 32'h3);
        check("preamble high", {31'h0, preamble_detect}, 32'h1);
        edge_clk_first <= 1'h0;
        edge_clk_second <= 1'h1;
        cyc(8);
        check("ddr edge second", {30'h0, pad_out}, 32'h0);
        apb(1'h1, io_cell_pkg::CFG_OFS, 32'h8, 32'h0, 32'h0, 1'h0, "gear cfg");
        for (int k = 0; k < 4; k++)
        begin
            {write_gear_clk_a, write_gear_clk_b} <= k[1:0];
            cyc(8);
            check("gear out", {30'h0, pad_out}, {30'h0, GEAR_EXP[2*k +: 2]});
        end
        apb(1'h1, io_cell_pkg::SHIFT_OFS, 32'h180, 32'h0, 32'h0, 1'h0, "invert wr");
        cyc(4);
        check("shift invert", {30'h0, pad_out}, 32'h1);
        $display("pad test done");
        local_set_reset <= 1'h1;
        cyc(4);
        check("local sr", {28'h0, pad_out, pad_tristate_ctl}, 32'h3);
        local_set_reset <= 1'h0;
        apb(1'h1, io_cell_pkg::CFG_OFS, 32'h10000, 32'h0, 32'h0, 1'h0, "cfg wr");
        apb(1'h0, io_cell_pkg::CFG_OFS, 32'h0, 32'hFFFFFFFF, 32'h10000, 1'h0, "cfg");
        global_set_reset_n <= 1'h0;
        cyc(4);
        check("global sr", {28'h0, pad_out, pad_tristate_ctl}, 32'hF);
        global_set_reset_n <= 1'h1;
        apb(1'h1, io_cell_pkg::CFG_OFS, 32'h600, 32'h0, 32'h0, 1'h0, "diff cfg");
        cyc(4);
        check("diff pair", {28'h0, pad_out, pad_tristate_ctl}, 32'h4);
        check("bottom valid", {31'h0, capture_valid_flag}, 32'h0);
        $display("set reset test done");
        report_and_stop();
    end
endmodule // io_cell_pair_test
